// *** tb/dcs_ctrl_props.sv ***
`timescale 1ns/1ps
`include "dcs_map.svh"
module dcs_ctrl_props (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic       ack_o,
  input wire logic       key_esc_i,
  input wire logic       fault_boot_i,
  input wire logic       run_o,
  input wire logic       jog_o,
  input wire logic       decel_stop_o,
  input wire logic       remote_o,
  input wire logic       set_led_flash_o,
  input wire logic [7:0] serial_station_number_o,
  input wire logic [1:0] serial_protocol_select_o,
  input wire logic [2:0] serial_baud_code_o,
  input wire logic [1:0] serial_frame_format_o
);
  logic       wr;
  logic [1:0] esc_fn;
  logic       fb_seen;
  assign wr = cyc_i && stb_i && we_i && !ack_o;

  // shadow of the escape function; registers are not visible here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      esc_fn <= `DCS_ESC_FUNC_RST;
    end else if (wr && adr_i == `DCS_ESC_FUNC_OFF && sel_i[0] && dat_i[1:0] <= 2'h2) begin
      esc_fn <= dat_i[1:0];
    end
  end

  // fault-boot escape is exempt, so remember any sighting of the strap
  always_ff @(posedge clk_i) begin
    fb_seen <= rst_i ? fault_boot_i : (fb_seen | fault_boot_i);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_req; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack after request");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_defaults;
    $fell(rst_i) |-> serial_station_number_o == `DCS_STATION_RST && remote_o &&
      serial_baud_code_o == `DCS_BAUD_RST && serial_protocol_select_o == `DCS_PROTO_RST &&
      serial_frame_format_o == `DCS_FRAME_RST;
  endproperty
  a_defaults: assert property (p_defaults) else $error("serial defaults wrong");
  property p_station; serial_station_number_o inside {[8'h01:8'hfa]}; endproperty
  a_station: assert property (p_station) else $error("station out of range");
  property p_led; set_led_flash_o == !remote_o; endproperty
  a_led: assert property (p_led) else $error("set led disagrees with mode");
  property p_esc_set;
    wr && adr_i == `DCS_ESC_FUNC_OFF && sel_i[0] && dat_i[1:0] == 2'h2 |=> remote_o;
  endproperty
  a_esc_set: assert property (p_esc_set) else $error("not remote after esc setup");
  property p_esc_toggle;
    key_esc_i && esc_fn == 2'h2 && !wr |=> remote_o != $past(remote_o);
  endproperty
  a_esc_toggle: assert property (p_esc_toggle) else $error("escape did not toggle");
  property p_esc_off;
    key_esc_i && esc_fn != 2'h2 && !fb_seen && !wr |=> $stable(remote_o);
  endproperty
  a_esc_off: assert property (p_esc_off) else $error("escape toggled while off");
  property p_stop_local; $fell(remote_o) |-> ##[0:1] !run_o; endproperty
  a_stop_local: assert property (p_stop_local) else $error("run kept into local");
  property p_decel; decel_stop_o |-> !run_o && !jog_o; endproperty
  a_decel: assert property (p_decel) else $error("running while prevented");

  c_local: cover property ($fell(remote_o));
  c_decel: cover property ($rose(decel_stop_o));
  c_jog: cover property (jog_o && !remote_o);
endmodule

bind dcs_ctrl dcs_ctrl_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .ack_o, .key_esc_i, .fault_boot_i, .run_o, .jog_o, .decel_stop_o, .remote_o,
  .set_led_flash_o, .serial_station_number_o, .serial_protocol_select_o,
  .serial_baud_code_o, .serial_frame_format_o);

// *** tb/dcs_far_side.sv ***
`timescale 1ns/1ps
module dcs_far_side (
  input  wire logic       clk_i,
  output logic      [4:0] term_o,
  output logic            fault_boot_o,
  output logic            comm_valid_o,
  output logic            comm_run_o,
  output logic            comm_rev_o
);
  // forward terminal already closed at power-on, so it must re-arm
  initial begin
    term_o       = 5'h01;
    fault_boot_o = 1'b0;
    comm_valid_o = 1'b0;
    comm_run_o   = 1'b1;
    comm_rev_o   = 1'b1;
  end

  // terminal levels change only just after an edge
  task automatic set_terms(input logic [4:0] v);
    @(posedge clk_i);
    term_o <= v;
  endtask

  task automatic set_fault(input logic v);
    @(posedge clk_i);
    fault_boot_o <= v;
  endtask

  // one command frame; gap models a slow upper controller
  task automatic send_cmd(input logic run, input logic rev, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    comm_valid_o <= 1'b1;
    comm_run_o   <= run;
    comm_rev_o   <= rev;
    @(posedge clk_i);
    comm_valid_o <= 1'b0;
    comm_run_o   <= ~run;  // fields are junk outside a frame
    comm_rev_o   <= ~rev;
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`include "dcs_map.svh"
module tb_top;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, fault_boot_i, key_jog_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [4:0]  keys, term_i;
  logic        comm_valid_i, comm_run_i, comm_rev_i, ext_run_i, ext_rev_i;
  logic        run_o, reverse_o, jog_o, decel_stop_o, remote_o, set_led_flash_o;
  logic [7:0]  serial_station_number_o;
  logic [1:0]  serial_protocol_select_o, serial_frame_format_o;
  logic [2:0]  serial_baud_code_o;
  int          err_count, num_checks;
  logic [3:0]  wsel = 4'hf;

  dcs_ctrl uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .term_i, .fault_boot_i, .key_run_i(keys[0]), .key_stop_i(keys[1]),
    .key_rev_i(keys[2]), .key_fwd_i(keys[3]), .key_esc_i(keys[4]), .key_jog_i,
    .comm_valid_i, .comm_run_i, .comm_rev_i, .ext_run_i, .ext_rev_i, .run_o, .reverse_o,
    .jog_o, .decel_stop_o, .remote_o, .set_led_flash_o, .serial_station_number_o,
    .serial_protocol_select_o, .serial_baud_code_o, .serial_frame_format_o);
  dcs_far_side far (.clk_i, .term_o(term_i), .fault_boot_o(fault_boot_i),
    .comm_valid_o(comm_valid_i), .comm_run_o(comm_run_i), .comm_rev_o(comm_rev_i));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, wsel, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 40) err_count++;
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask

  // one-cycle keypad pulse: 0 run, 1 stop, 2 rev, 3 fwd, 4 escape
  task automatic press(input int k);
    @(posedge clk_i);
    keys[k] <= 1'b1;
    @(posedge clk_i);
    keys[k] <= 1'b0;
  endtask

  task automatic defaults;
    logic [7:0] exp [4];
    exp = '{8'h01, 8'h00, 8'h03, 8'h00};
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
      chk(rd, {24'h0, exp[i]});
    end
    wb(1'b1, `DCS_STATION_OFF, 32'hfb);
    wb(1'b1, `DCS_STATION_OFF, 32'h00);
    wb(1'b0, `DCS_STATION_OFF, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, `DCS_STATION_OFF, 32'hfa);
    chk(serial_station_number_o, 32'hfa);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic serial_src;
    for (int s = 0; s <= 6; s++) begin
      wb(1'b1, `DCS_CMD_SRC_OFF, 32'(s));
      wb(1'b0, `DCS_CMD_SRC_OFF, 32'h0);
      chk(rd, (s == 6) ? 32'h5 : 32'(s));
    end
    wb(1'b1, `DCS_CMD_SRC_OFF, 32'h3);
    far.send_cmd(1'b1, 1'b1, 0);
    tick(2);
    chk({run_o, reverse_o}, 32'h3);
    far.send_cmd(1'b0, 1'b0, 7);
    tick(2);
    chk(run_o, 32'h0);
  endtask

  task automatic esc_modes;
    press(4);
    tick(2);
    chk(remote_o, 32'h1);
    wb(1'b1, `DCS_ESC_FUNC_OFF, 32'h2);
    chk(remote_o, 32'h1);
    far.send_cmd(1'b1, 1'b0, 0);
    tick(2);
    chk(run_o, 32'h1);
    press(4);
    tick(2);
    chk({remote_o, set_led_flash_o, run_o}, 32'h2);
    press(0);
    tick(2);
    chk(run_o, 32'h1);
    press(1);
    tick(2);
    chk(run_o, 32'h0);
    press(0);
    press(4);
    tick(3);
    chk({remote_o, set_led_flash_o, run_o}, 32'h4);
    far.send_cmd(1'b1, 1'b0, 3);
    tick(2);
    chk(run_o, 32'h1);
    far.send_cmd(1'b0, 1'b0, 0);
  endtask

  // P1 run/forward, P2 reverse, P3 run enable; forward still closed from power-on
  task automatic term_modes;
    wb(1'b1, `DCS_TERM_FUNC_OFF, 32'h0000d081);
    wb(1'b1, `DCS_CMD_SRC_OFF, 32'h2);
    tick(5);
    chk(run_o, 32'h0);
    far.set_terms(5'h00);
    tick(5);
    far.set_terms(5'h01);
    tick(5);
    chk({run_o, reverse_o}, 32'h2);
    far.set_terms(5'h03);
    tick(5);
    chk({run_o, reverse_o}, 32'h3);
    press(4);
    tick(2);
    chk(run_o, 32'h0);
    @(posedge clk_i);
    key_jog_i <= 1'b1;
    tick(5);
    chk(jog_o, 32'h0);
    far.set_terms(5'h07);
    tick(5);
    chk(jog_o, 32'h1);
    key_jog_i <= 1'b0;
    far.set_terms(5'h03);
    press(4);
    tick(4);
    chk({run_o, reverse_o}, 32'h3);
    wb(1'b1, `DCS_RUN_PREVENT_OFF, 32'h2);
    tick(3);
    chk({decel_stop_o, run_o}, 32'h2);
    far.set_terms(5'h01);
    wb(1'b1, `DCS_RUN_PREVENT_OFF, 32'h1);
    tick(5);
    chk({decel_stop_o, run_o}, 32'h2);
    wb(1'b1, `DCS_RUN_PREVENT_OFF, 32'h0);
    tick(3);
    chk({decel_stop_o, run_o}, 32'h1);
    far.set_terms(5'h00);
    tick(5);
  endtask

  // escape setting forces remote; sources 4, 5, 0, 1; byte-lane write
  task automatic more_srcs;
    press(4);
    wb(1'b1, `DCS_ESC_FUNC_OFF, 32'h2);
    chk(remote_o, 32'h1);
    wb(1'b1, `DCS_CMD_SRC_OFF, 32'h4);
    {ext_run_i, ext_rev_i} <= 2'b11;
    tick(2);
    chk({run_o, reverse_o}, 32'h3);
    wb(1'b1, `DCS_CMD_SRC_OFF, 32'h5);
    {ext_run_i, ext_rev_i} <= 2'b10;
    tick(2);
    chk({run_o, reverse_o}, 32'h2);
    wb(1'b1, `DCS_CMD_SRC_OFF, 32'h0);
    press(0);
    press(2);
    tick(2);
    chk({run_o, reverse_o}, 32'h3);
    press(3);
    press(1);
    wsel = 4'hc;
    wb(1'b1, `DCS_TERM_FUNC_OFF, 32'h0204_0000);
    wsel = 4'hf;
    wb(1'b1, `DCS_CMD_SRC_OFF, 32'h1);
    far.set_terms(5'h08);
    tick(4);
    chk({run_o, reverse_o}, 32'h2);
    far.set_terms(5'h10);
    tick(4);
    chk({run_o, reverse_o}, 32'h3);
    far.set_terms(5'h00);
  endtask

  // reset that cleared a fault: local first, then all terminals must open
  task automatic fault_boot;
    far.set_fault(1'b1);
    rst_i <= 1'b1;
    tick(6);
    rst_i <= 1'b0;
    tick(6);
    chk(remote_o, 32'h0);
    far.set_fault(1'b0);
    wb(1'b1, `DCS_TERM_FUNC_OFF, 32'h0000d081);
    wb(1'b1, `DCS_CMD_SRC_OFF, 32'h2);
    far.set_terms(5'h01);
    press(4);
    tick(5);
    chk({remote_o, run_o}, 32'h2);
    far.set_terms(5'h00);
    tick(5);
    far.set_terms(5'h01);
    tick(5);
    chk(run_o, 32'h1);
  endtask

  // main sequence; keys, jog and external levels start low
  initial begin
    {rst_i, cyc_i, stb_i, we_i, key_jog_i, ext_run_i, ext_rev_i} = 7'h40;
    {adr_i, sel_i, dat_i, keys} = '0;
    err_count = 0;
    num_checks = 0;
    tick(6);
    rst_i <= 1'b0;
    tick(5);
    defaults();
    serial_src();
    esc_modes();
    term_modes();
    more_srcs();
    fault_boot();
    test_done();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    tick(20000);
    err_count++;
    test_done();
  end
endmodule

// *** verilog/dcs_ctrl.sv ***
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "dcs_map.svh"

module dcs_ctrl #(
  parameter int N_TERM          = 5,
  parameter bit PON_RUN_DEFAULT = 1'b0
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // classic wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // terminal pins and fault-boot strap, asynchronous
  input  wire logic [N_TERM-1:0]     term_i,
  input  wire logic                  fault_boot_i,
  // keypad events, one-cycle pulses except jog
  input  wire logic                  key_run_i,
  input  wire logic                  key_stop_i,
  input  wire logic                  key_rev_i,
  input  wire logic                  key_fwd_i,
  input  wire logic                  key_esc_i,
  input  wire logic                  key_jog_i,
  // serial engine command, same clock
  input  wire logic                  comm_valid_i,
  input  wire logic                  comm_run_i,
  input  wire logic                  comm_rev_i,
  // field bus / user sequence command levels
  input  wire logic                  ext_run_i,
  input  wire logic                  ext_rev_i,
  // drive outputs
  output logic                       run_o,
  output logic                       reverse_o,
  output logic                       jog_o,
  output logic                       decel_stop_o,
  output logic                       remote_o,
  output logic                       set_led_flash_o,
  // serial engine configuration
  output logic      [7:0]            serial_station_number_o,
  output logic      [1:0]            serial_protocol_select_o,
  output logic      [2:0]            serial_baud_code_o,
  output logic      [1:0]            serial_frame_format_o
);

  initial begin
    if (N_TERM != 5) $error("dcs_ctrl: N_TERM must be 5");
  end

  localparam int TFW = `DCS_TF_WIDTH;

  // settings
  dcs_pkg::dcs_src_t           cmd_src;
  logic [1:0]                  escape_key_function;
  logic [1:0]                  run_prevent;
  logic                        pon_run;
  logic [N_TERM*TFW-1:0]       terminal_function_assign;

  // state
  dcs_pkg::dcs_mode_t          mode;
  logic [N_TERM-1:0]           term_m;
  logic [N_TERM-1:0]           term_s;
  logic [N_TERM-1:0]           armed;
  logic                        fb_m;
  logic                        fb_s;
  logic [1:0]                  boot_cnt;
  logic                        fault_boot;
  logic                        wait_all_off;
  logic                        local_run;
  logic                        local_rev;
  logic                        rem_run;
  logic                        rem_rev;
  logic                        esc_toggle;
  logic                        wr_stb;
  logic                        rd_stb;

  // merges byte lanes of a write into the old word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // mask of terminals whose assigned function equals code
  function automatic logic [N_TERM-1:0] tf_hit(input logic [N_TERM*TFW-1:0] tfa,
                                               input logic [TFW-1:0] code);
    logic [N_TERM-1:0] m;
    m = '0;
    for (int i = 0; i < N_TERM; i++) begin
      m[i] = (tfa[i*TFW +: TFW] == code);
    end
    return m;
  endfunction

  assign wr_stb = cyc_i && stb_i && we_i && !ack_o;
  assign rd_stb = cyc_i && stb_i && !we_i && !ack_o;
  logic [31:0] tfa_next;
  assign tfa_next = wmerge({2'h0, terminal_function_assign}, dat_i, sel_i);

  // two-flop synchronisers for pins; only the second stage is used
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_m <= '0;
      term_s <= '0;
      fb_m   <= 1'b0;
      fb_s   <= 1'b0;
    end else begin
      term_m <= term_i;
      term_s <= term_m;
      fb_m   <= fault_boot_i;
      fb_s   <= fb_m;
    end
  end

  // take the fault-boot level once the synchroniser has settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_cnt   <= 2'h0;
      fault_boot <= 1'b0;
    end else if (boot_cnt != `DCS_BOOT_CYCLES) begin
      boot_cnt <= boot_cnt + 2'h1;
      if (boot_cnt == `DCS_BOOT_CYCLES - 2'h1) fault_boot <= fb_s;
    end
  end

  logic boot_edge;
  assign boot_edge = (boot_cnt == `DCS_BOOT_CYCLES - 2'h1);

  // decoded terminal functions
  logic [N_TERM-1:0] is_fx, is_rx, is_run_en, is_jf, is_jr, is_pre, gated, eff;
  assign is_fx     = tf_hit(terminal_function_assign, `DCS_TF_FX);
  assign is_rx     = tf_hit(terminal_function_assign, `DCS_TF_RX);
  assign is_run_en = tf_hit(terminal_function_assign, `DCS_TF_RUN_EN);
  assign is_jf     = tf_hit(terminal_function_assign, `DCS_TF_JOG_FWD);
  assign is_jr     = tf_hit(terminal_function_assign, `DCS_TF_JOG_REV);
  assign is_pre    = tf_hit(terminal_function_assign, `DCS_TF_PREEXC);
  // run, jog and pre-excitation terminals need re-arming; others pass
  assign gated     = is_fx | is_rx | is_jf | is_jr | is_pre;
  assign eff       = wait_all_off ? '0 : (term_s & (armed | ~gated));

  // a terminal arms once seen off; power-on run arms all at boot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed <= '0;
    end else if (boot_edge && pon_run) begin
      armed <= '1;
    end else if (boot_cnt == `DCS_BOOT_CYCLES) begin
      // the synchroniser resets low, so arming waits until it shows the pins
      armed <= armed | ~term_s;
    end
  end

  // after a fault boot, remote entry by the escape key holds terminals until all are off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_all_off <= 1'b0;
    end else if (esc_toggle && mode == dcs_pkg::DCS_MODE_LOCAL && fault_boot) begin
      wait_all_off <= 1'b1;
    end else if (term_s == '0) begin
      wait_all_off <= 1'b0;
    end
  end

  // escape toggles only with function 2, or with any function after a fault boot
  assign esc_toggle = key_esc_i &&
                      (escape_key_function == `DCS_ESC_LOCAL_REMOTE || fault_boot);

  // operating mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= dcs_pkg::DCS_MODE_REMOTE;
    end else if (boot_edge && fb_s) begin
      mode <= dcs_pkg::DCS_MODE_LOCAL;
    end else if (wr_stb && adr_i == `DCS_ESC_FUNC_OFF && sel_i[0] &&
                 dat_i[1:0] == `DCS_ESC_LOCAL_REMOTE) begin
      mode <= dcs_pkg::DCS_MODE_REMOTE;
    end else if (esc_toggle) begin
      case (mode)
        dcs_pkg::DCS_MODE_REMOTE: mode <= dcs_pkg::DCS_MODE_LOCAL;
        dcs_pkg::DCS_MODE_LOCAL:  mode <= dcs_pkg::DCS_MODE_REMOTE;
        default:                  mode <= dcs_pkg::DCS_MODE_REMOTE;
      endcase
    end
  end

  logic is_local;
  assign is_local = (mode == dcs_pkg::DCS_MODE_LOCAL);

  // keypad run latch in local mode; an escape toggle or the stop key clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      local_run <= 1'b0;
      local_rev <= 1'b0;
    end else begin
      if (esc_toggle || key_stop_i) local_run <= 1'b0;
      else if (is_local && key_run_i) local_run <= 1'b1;
      if (key_rev_i) local_rev <= 1'b1;
      else if (key_fwd_i) local_rev <= 1'b0;
    end
  end

  // remote digital source latch: keypad or serial link
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rem_run <= 1'b0;
      rem_rev <= 1'b0;
    end else if (esc_toggle) begin
      rem_run <= 1'b0;
    end else if (!is_local && cmd_src == dcs_pkg::DCS_SRC_SERIAL) begin
      if (comm_valid_i) begin
        rem_run <= comm_run_i;
        rem_rev <= comm_rev_i;
      end
    end else if (!is_local && cmd_src == dcs_pkg::DCS_SRC_KEYPAD) begin
      if (key_stop_i) rem_run <= 1'b0;
      else if (key_run_i) rem_run <= 1'b1;
      if (key_rev_i) rem_rev <= 1'b1;
      else if (key_fwd_i) rem_rev <= 1'b0;
    end else begin
      rem_run <= 1'b0;
    end
  end

  // command selection; terminal paths carry no latch, so remote entry follows them
  logic fx, rx, run_en, jog_f, jog_r, dem_run, dem_rev, dem_jog;
  assign fx     = |(eff & is_fx);
  assign rx     = |(eff & is_rx);
  assign run_en = |(term_s & is_run_en);
  assign jog_f  = |(eff & is_jf);
  assign jog_r  = |(eff & is_jr);

  always_comb begin
    dem_run = 1'b0;
    dem_rev = 1'b0;
    dem_jog = 1'b0;
    if (is_local) begin
      dem_run = local_run;
      dem_rev = local_rev;
      dem_jog = key_jog_i && run_en;
    end else begin
      case (cmd_src)
        dcs_pkg::DCS_SRC_TERM_FR: begin
          dem_run = fx ^ rx; // both on or both off is a stop
          dem_rev = rx && !fx;
          dem_jog = jog_f ^ jog_r;
          if (!dem_run && dem_jog) dem_rev = jog_r;
        end
        dcs_pkg::DCS_SRC_TERM_RD: begin
          dem_run = fx;
          dem_rev = rx;
          dem_jog = jog_f ^ jog_r;
          if (!dem_run && dem_jog) dem_rev = jog_r;
        end
        dcs_pkg::DCS_SRC_KEYPAD,
        dcs_pkg::DCS_SRC_SERIAL: begin
          dem_run = rem_run;
          dem_rev = rem_rev;
        end
        dcs_pkg::DCS_SRC_FIELDBUS,
        dcs_pkg::DCS_SRC_USERSEQ: begin
          dem_run = ext_run_i;
          dem_rev = ext_rev_i;
        end
        default: begin
          dem_run = 1'b0;
        end
      endcase
    end
  end

  // a demand in a prevented direction ramps to zero and holds
  logic blocked;
  assign blocked = (dem_run || dem_jog) &&
                   ((run_prevent == `DCS_PREVENT_FWD && !dem_rev) ||
                    (run_prevent == `DCS_PREVENT_REV && dem_rev));

  // registered drive commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_o        <= 1'b0;
      reverse_o    <= 1'b0;
      jog_o        <= 1'b0;
      decel_stop_o <= 1'b0;
    end else begin
      run_o        <= dem_run && !blocked;
      jog_o        <= dem_jog && !dem_run && !blocked;
      reverse_o    <= dem_rev;
      decel_stop_o <= blocked;
    end
  end

  assign remote_o        = !is_local;
  assign set_led_flash_o = is_local;

  // register writes; out-of-range values are ignored, except terminal function codes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_src                  <= dcs_pkg::dcs_src_t'(`DCS_CMD_SRC_RST);
      escape_key_function      <= `DCS_ESC_FUNC_RST;
      run_prevent              <= `DCS_RUN_PREVENT_RST;
      pon_run                  <= PON_RUN_DEFAULT;
      serial_station_number_o  <= `DCS_STATION_RST;
      serial_protocol_select_o <= `DCS_PROTO_RST;
      serial_baud_code_o       <= `DCS_BAUD_RST;
      serial_frame_format_o    <= `DCS_FRAME_RST;
      terminal_function_assign <= `DCS_TERM_FUNC_RST;
    end else if (wr_stb) begin
      if (adr_i == `DCS_CMD_SRC_OFF) begin
        if (sel_i[0] && dat_i[2:0] <= `DCS_CMD_SRC_MAX)
          cmd_src <= dcs_pkg::dcs_src_t'(dat_i[2:0]);
      end else if (adr_i == `DCS_ESC_FUNC_OFF) begin
        if (sel_i[0] && dat_i[1:0] <= `DCS_ESC_FUNC_MAX)
          escape_key_function <= dat_i[1:0];
      end else if (adr_i == `DCS_RUN_PREVENT_OFF) begin
        if (sel_i[0] && dat_i[1:0] <= `DCS_PREVENT_MAX)
          run_prevent <= dat_i[1:0];
      end else if (adr_i == `DCS_PON_RUN_OFF) begin
        if (sel_i[0]) pon_run <= dat_i[0];
      end else if (adr_i == `DCS_STATION_OFF) begin
        if (sel_i[0] && dat_i[7:0] >= `DCS_STATION_MIN && dat_i[7:0] <= `DCS_STATION_MAX)
          serial_station_number_o <= dat_i[7:0];
      end else if (adr_i == `DCS_PROTO_OFF) begin
        if (sel_i[0] && dat_i[1:0] <= `DCS_PROTO_MAX) serial_protocol_select_o <= dat_i[1:0];
      end else if (adr_i == `DCS_BAUD_OFF) begin
        if (sel_i[0]) serial_baud_code_o <= dat_i[2:0];
      end else if (adr_i == `DCS_FRAME_OFF) begin
        if (sel_i[0]) serial_frame_format_o <= dat_i[1:0];
      end else if (adr_i == `DCS_TERM_FUNC_OFF) begin
        terminal_function_assign <= tfa_next[N_TERM*TFW-1:0];
      end
    end
  end

  // status word: the block's own state
  logic [31:0] status;
  always_comb begin
    status                          = 32'h0000_0000;
    status[`DCS_ST_REMOTE]          = !is_local;
    status[`DCS_ST_RUN]             = run_o;
    status[`DCS_ST_REV]             = reverse_o;
    status[`DCS_ST_JOG]             = jog_o;
    status[`DCS_ST_DECEL]           = decel_stop_o;
    status[`DCS_ST_WAIT_OFF]        = wait_all_off;
    status[`DCS_ST_FAULT_BOOT]      = fault_boot;
    status[`DCS_ST_ARMED_LSB +: N_TERM] = armed;
  end

  // read mux; unmapped addresses read zero and still ack
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (adr_i == `DCS_CMD_SRC_OFF) rdata[2:0] = cmd_src;
    else if (adr_i == `DCS_ESC_FUNC_OFF) rdata[1:0] = escape_key_function;
    else if (adr_i == `DCS_RUN_PREVENT_OFF) rdata[1:0] = run_prevent;
    else if (adr_i == `DCS_PON_RUN_OFF) rdata[0] = pon_run;
    else if (adr_i == `DCS_STATION_OFF) rdata[7:0] = serial_station_number_o;
    else if (adr_i == `DCS_PROTO_OFF) rdata[1:0] = serial_protocol_select_o;
    else if (adr_i == `DCS_BAUD_OFF) rdata[2:0] = serial_baud_code_o;
    else if (adr_i == `DCS_FRAME_OFF) rdata[1:0] = serial_frame_format_o;
    else if (adr_i == `DCS_TERM_FUNC_OFF) rdata[N_TERM*TFW-1:0] = terminal_function_assign;
    else if (adr_i == `DCS_STATUS_OFF) rdata = status;
  end

  // one wait state: ack one edge after the strobe, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (rd_stb) dat_o <= rdata;
    end
  end

endmodule

// *** verilog/dcs_map.svh ***
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

// register byte offsets
`define DCS_CMD_SRC_OFF      8'h00
`define DCS_ESC_FUNC_OFF     8'h04
`define DCS_RUN_PREVENT_OFF  8'h08
`define DCS_PON_RUN_OFF      8'h0c
`define DCS_STATION_OFF      8'h10
`define DCS_PROTO_OFF        8'h14
`define DCS_BAUD_OFF         8'h18
`define DCS_FRAME_OFF        8'h1c
`define DCS_TERM_FUNC_OFF    8'h20
`define DCS_STATUS_OFF       8'h24

// reset values
`define DCS_CMD_SRC_RST      3'h0
`define DCS_ESC_FUNC_RST     2'h0
`define DCS_RUN_PREVENT_RST  2'h0
`define DCS_PON_RUN_RST      1'h0
`define DCS_STATION_RST      8'h01
`define DCS_PROTO_RST        2'h0
`define DCS_BAUD_RST         3'h3
`define DCS_FRAME_RST        2'h0
`define DCS_TERM_FUNC_RST    30'h0000_0000

// setting values and limits
`define DCS_ESC_LOCAL_REMOTE 2'h2
`define DCS_CMD_SRC_MAX      3'h5
`define DCS_ESC_FUNC_MAX     2'h2
`define DCS_PREVENT_MAX      2'h2
`define DCS_PREVENT_FWD      2'h1
`define DCS_PREVENT_REV      2'h2
`define DCS_STATION_MIN      8'h01
`define DCS_STATION_MAX      8'hfa
`define DCS_PROTO_MAX        2'h2
`define DCS_BAUD_MAX         3'h7
`define DCS_FRAME_MAX        2'h3

// terminal function codes
`define DCS_TF_WIDTH         6
`define DCS_TF_FX            6'h01
`define DCS_TF_RX            6'h02
`define DCS_TF_RUN_EN        6'h0d
`define DCS_TF_JOG_FWD       6'h2e
`define DCS_TF_JOG_REV       6'h2f
`define DCS_TF_PREEXC        6'h30
`define DCS_TF_MAX           6'h36

// status bit positions
`define DCS_ST_REMOTE        0
`define DCS_ST_RUN           1
`define DCS_ST_REV           2
`define DCS_ST_JOG           3
`define DCS_ST_DECEL         4
`define DCS_ST_WAIT_OFF      5
`define DCS_ST_FAULT_BOOT    6
`define DCS_ST_ARMED_LSB     8

// settle cycles before the fault-boot level is taken
`define DCS_BOOT_CYCLES      2'h3

`endif

// *** verilog/dcs_pkg.sv ***
package dcs_pkg;

  // operating mode, one-hot
  typedef enum logic [1:0] {
    DCS_MODE_REMOTE = 2'b01,
    DCS_MODE_LOCAL  = 2'b10
  } dcs_mode_t;

  // run command source setting
  typedef enum logic [2:0] {
    DCS_SRC_KEYPAD   = 3'h0,
    DCS_SRC_TERM_FR  = 3'h1,
    DCS_SRC_TERM_RD  = 3'h2,
    DCS_SRC_SERIAL   = 3'h3,
    DCS_SRC_FIELDBUS = 3'h4,
    DCS_SRC_USERSEQ  = 3'h5
  } dcs_src_t;

endpackage
